// ---- src/ers_read_sequencer.v ----
`timescale 1ns/10ps
`include "ers_defines.vh"
// Functional notes
// - Address counter holds last address plus one across transactions.
// - Read counting wraps from last array byte to first.
// - Write counting wraps inside the current page only.
// - Read-direction address acknowledged, then byte at counter is sent.
// - After repeated start, acknowledge read address and send loaded byte.
// - Each sent byte outside the lock status area advances address; master acknowledge sends next byte.
// - Serial number area bits 10:9 x1; low four bits pick byte.
// - Serial number byte index wraps after sixteenth byte.
// - Sector area bits 10:9 00; bits 4:0 pick byte.
// - Sector byte index increments and wraps from last to first.
// - Sector write acknowledged only while sector unlocked.
// - Start mid-command resets sequencing, truncated command dropped.
// - Stop returns device to idle standby.
// - Lock status area bits 10:9 10, other bits ignored.
// - Lock status byte bit 1 is one when locked.
// - Lock status byte repeats on every acknowledged byte.
// - Upper nibble 1010 selects array, 1011 the special area.
// - Chip-select bits must match the select pins.
// - Matching address acknowledged low, mismatch returns to standby.
module ers_read_sequencer #(
  parameter ADDR_W = `ERS_ADDR_W,
  parameter PAGE_W = `ERS_PAGE_W
) (
  input wire ref_clk,
  input wire rstn,
  input wire sclIn,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOutEnN,
  input wire chip_select_bit_high,
  input wire chip_select_bit_mid,
  input wire chip_select_bit_low,
  input wire sectorLocked,
  input wire [127:0] factory_serial_number,
  output reg busy,
  output reg [ADDR_W-1:0] addrCounter
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 7'h01;
  localparam S_DEV = 7'h02;
  localparam S_ACK = 7'h04;
  localparam S_WADDR = 7'h08;
  localparam S_WDATA = 7'h10;
  localparam S_SEND = 7'h20;
  localparam S_MACK = 7'h40;

  localparam PH_DEV = 2'h0;
  localparam PH_HI = 2'h1;
  localparam PH_LO = 2'h2;
  localparam PH_DATA = 2'h3;

  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;
  wire sdaLevel;
  wire [7:0] arrayByte;
  wire [7:0] sectorByte;
  wire [7:0] snByte;

  reg [6:0] state_reg;
  reg [1:0] phase_reg;
  reg [7:0] shift_reg;
  reg [2:0] bitCnt_reg;
  reg special_reg;
  reg [1:0] area_reg;
  reg ackThis_reg;
  reg [3:0] snIdx_reg;
  reg [4:0] secIdx_reg;
  reg [7:0] hiByte_reg;
  reg wrEn_reg;
  reg sectorWrEn_reg;
  reg [ADDR_W-1:0] wrAddr_reg;
  reg [7:0] wrData_reg;
  reg [7:0] txByte;
  reg [2:0] csMeta_reg;
  reg [2:0] csSync_reg;

  // ----------------------------------------
  // Address arithmetic
  // ----------------------------------------
  function [ADDR_W-1:0] readNext;
    input [ADDR_W-1:0] a;
    begin
      readNext = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  function [ADDR_W-1:0] writeNext;
    input [ADDR_W-1:0] a;
    reg [PAGE_W-1:0] low;
    begin
      low = a[PAGE_W-1:0] + {{(PAGE_W-1){1'b0}}, 1'b1};
      writeNext = {a[ADDR_W-1:PAGE_W], low};
    end
  endfunction

  ers_bus_sync u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startCond(startCond),
    .stopCond(stopCond),
    .sdaLevel(sdaLevel)
  );

  ers_storage #(
    .ADDR_W(ADDR_W)
  ) u_store (
    .ref_clk(ref_clk),
    .wrEn(wrEn_reg),
    .wrAddr(wrAddr_reg),
    .wrData(wrData_reg),
    .sectorWrEn(sectorWrEn_reg),
    .sectorAddr(secIdx_reg),
    .rdAddr(addrCounter),
    .snAddr(snIdx_reg),
    .factory_serial_number(factory_serial_number),
    .arrayByte(arrayByte),
    .sectorByte(sectorByte),
    .snByte(snByte)
  );

  // ----------------------------------------
  // Outgoing byte selection
  // ----------------------------------------
  always @* begin
    if (!special_reg) begin
      txByte = arrayByte;
    end else if (area_reg[0]) begin
      txByte = snByte;
    end else if (area_reg == `ERS_AREA_LOCK) begin
      txByte = 8'h00;
      txByte[`ERS_LOCK_BIT] = sectorLocked;
    end else begin
      txByte = sectorByte;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      phase_reg <= PH_DEV;
      shift_reg <= 8'h00;
      bitCnt_reg <= 3'h0;
      special_reg <= 1'b0;
      area_reg <= 2'h0;
      ackThis_reg <= 1'b0;
      snIdx_reg <= 4'h0;
      secIdx_reg <= 5'h00;
      hiByte_reg <= 8'h00;
      wrEn_reg <= 1'b0;
      sectorWrEn_reg <= 1'b0;
      wrAddr_reg <= {ADDR_W{1'b0}};
      wrData_reg <= 8'h00;
      addrCounter <= {ADDR_W{1'b0}};
      sdaOut <= 1'b1;
      sdaOutEnN <= 1'b1;
      busy <= 1'b0;
      csMeta_reg <= 3'h0;
      csSync_reg <= 3'h0;
    end else begin
      wrEn_reg <= 1'b0;
      sectorWrEn_reg <= 1'b0;
      // Straps are pins, so they pass two flops like the bus lines
      csMeta_reg <= {chip_select_bit_high, chip_select_bit_mid, chip_select_bit_low};
      csSync_reg <= csMeta_reg;
      // Sector index moves only after the store has used it
      if (sectorWrEn_reg) begin
        secIdx_reg <= secIdx_reg + 5'h01;
      end
      if (startCond) begin
        // Any pending command is dropped here, nothing is committed
        state_reg <= S_DEV;
        bitCnt_reg <= 3'h0;
        shift_reg <= 8'h00;
        sdaOutEnN <= 1'b1;
        busy <= 1'b1;
      end else if (stopCond) begin
        state_reg <= S_IDLE;
        sdaOutEnN <= 1'b1;
        busy <= 1'b0;
      end else begin
        case (state_reg)
          S_DEV, S_WADDR, S_WDATA: begin
            if (sclRise) begin
              shift_reg <= {shift_reg[6:0], sdaLevel};
              bitCnt_reg <= bitCnt_reg + 3'h1;
            end
            // A legal address is never zero, so the fall that ends a start is skipped
            if (sclFall && bitCnt_reg == 3'h0 && shift_reg != 8'h00 && state_reg == S_DEV) begin
              if ((shift_reg[7:4] == `ERS_DEV_MAIN || shift_reg[7:4] == `ERS_DEV_SPECIAL) &&
                  shift_reg[3:1] == csSync_reg) begin
                sdaOut <= 1'b0;
                sdaOutEnN <= 1'b0;
                state_reg <= S_ACK;
                phase_reg <= shift_reg[0] ? PH_DATA : PH_HI;
                // Direction and area of a new address byte replace the dummy write's
                if (!shift_reg[0] || shift_reg[7:4] != `ERS_DEV_SPECIAL || !special_reg) begin
                  special_reg <= (shift_reg[7:4] == `ERS_DEV_SPECIAL);
                end
                ackThis_reg <= shift_reg[0];
              end else begin
                state_reg <= S_IDLE;
                busy <= 1'b0;
              end
              shift_reg <= 8'h00;
            end else if (sclFall && bitCnt_reg == 3'h0 && state_reg != S_DEV && ackThis_reg) begin
              ackThis_reg <= 1'b0;
              state_reg <= S_ACK;
              if (phase_reg == PH_HI) begin
                hiByte_reg <= shift_reg;
                sdaOut <= 1'b0;
                sdaOutEnN <= 1'b0;
                phase_reg <= PH_LO;
              end else if (phase_reg == PH_LO) begin
                sdaOut <= 1'b0;
                sdaOutEnN <= 1'b0;
                phase_reg <= PH_DATA;
                area_reg <= hiByte_reg[2:1];
                if (!special_reg) begin
                  addrCounter <= {hiByte_reg[3:0], shift_reg};
                end else begin
                  snIdx_reg <= shift_reg[3:0];
                  secIdx_reg <= shift_reg[4:0];
                end
              end else begin
                // Data byte of a write: sector and lock-status area writes report the lock
                if (special_reg && !area_reg[0] && sectorLocked) begin
                  sdaOutEnN <= 1'b1;
                end else begin
                  sdaOut <= 1'b0;
                  sdaOutEnN <= 1'b0;
                end
                wrData_reg <= shift_reg;
                if (!special_reg) begin
                  wrEn_reg <= 1'b1;
                  wrAddr_reg <= addrCounter;
                  addrCounter <= writeNext(addrCounter);
                end else if (area_reg == `ERS_AREA_SECTOR && !sectorLocked) begin
                  sectorWrEn_reg <= 1'b1;
                end
              end
            end
          end
          S_ACK: begin
            // Hold acknowledge through the ninth clock, leave on its fall
            if (sclFall) begin
              bitCnt_reg <= 3'h0;
              shift_reg <= 8'h00;
              ackThis_reg <= 1'b1;
              if (phase_reg == PH_DATA && ackThis_reg) begin
                state_reg <= S_SEND;
              end else begin
                sdaOutEnN <= 1'b1;
                state_reg <= (phase_reg == PH_DATA) ? S_WDATA : S_WADDR;
              end
            end
          end
          S_SEND: begin
            // Bit 7 goes out on entry, then each falling edge shifts
            if (bitCnt_reg == 3'h0 && !sdaOutEnN && shift_reg == 8'h00 && ackThis_reg) begin
              shift_reg <= {txByte[6:0], 1'b0};
              sdaOut <= txByte[7];
              ackThis_reg <= 1'b0;
              bitCnt_reg <= 3'h1;
            end else if (sclFall) begin
              if (bitCnt_reg == 3'h0) begin
                sdaOutEnN <= 1'b1;
                state_reg <= S_MACK;
                if (!special_reg) begin
                  addrCounter <= readNext(addrCounter);
                end else if (area_reg[0]) begin
                  snIdx_reg <= snIdx_reg + 4'h1;
                end else if (area_reg == `ERS_AREA_SECTOR) begin
                  secIdx_reg <= secIdx_reg + 5'h01;
                end
              end else begin
                sdaOut <= shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bitCnt_reg <= bitCnt_reg + 3'h1;
              end
            end
          end
          S_MACK: begin
            if (sclRise) begin
              ackThis_reg <= ~sdaLevel;
            end
            if (sclFall) begin
              if (ackThis_reg) begin
                state_reg <= S_SEND;
                sdaOutEnN <= 1'b0;
                bitCnt_reg <= 3'h0;
                shift_reg <= 8'h00;
              end else begin
                state_reg <= S_IDLE;
                busy <= 1'b0;
              end
            end
          end
          default: begin
            sdaOutEnN <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// ---- src/ers_defines.vh ----
`ifndef ERS_DEFINES_VH
`define ERS_DEFINES_VH
// ----------------------------------------
// Device address and word address layout
// ----------------------------------------
`define ERS_DEV_MAIN 4'ha
`define ERS_DEV_SPECIAL 4'hb
`define ERS_AREA_SECTOR 2'h0
`define ERS_AREA_LOCK 2'h2
`define ERS_ADDR_W 12
`define ERS_PAGE_W 5
`define ERS_SN_W 4
`define ERS_SECTOR_W 5
`define ERS_LOCK_BIT 1
`define ERS_SYNC_RESET 2'h3
`endif

// ---- src/ers_bus_sync.v ----
`timescale 1ns/10ps
// ----------------------------------------
// Two-flop synchronisers and condition detector
// ----------------------------------------
module ers_bus_sync (
  input wire ref_clk,
  input wire rstn,
  input wire sclIn,
  input wire sdaIn,
  output reg sclRise,
  output reg sclFall,
  output reg startCond,
  output reg stopCond,
  output reg sdaLevel
);
  reg [1:0] sclMeta_reg;
  reg [1:0] sdaMeta_reg;
  reg sclOld_reg;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sclMeta_reg <= 2'h3;
      sdaMeta_reg <= 2'h3;
      sclOld_reg <= 1'b1;
      sdaLevel <= 1'b1;
      sclRise <= 1'b0;
      sclFall <= 1'b0;
      startCond <= 1'b0;
      stopCond <= 1'b0;
    end else begin
      sclMeta_reg <= {sclMeta_reg[0], sclIn};
      sdaMeta_reg <= {sdaMeta_reg[0], sdaIn};
      sclOld_reg <= sclMeta_reg[1];
      sdaLevel <= sdaMeta_reg[1];
      sclRise <= sclMeta_reg[1] & ~sclOld_reg;
      sclFall <= ~sclMeta_reg[1] & sclOld_reg;
      // Data edge while the clock stays high marks a condition
      startCond <= sclMeta_reg[1] & sclOld_reg & sdaLevel & ~sdaMeta_reg[1];
      stopCond <= sclMeta_reg[1] & sclOld_reg & ~sdaLevel & sdaMeta_reg[1];
    end
  end
endmodule

// ---- src/ers_storage.v ----
`timescale 1ns/10ps
`include "ers_defines.vh"
// ----------------------------------------
// Read ports of the array, serial number and sector
// ----------------------------------------
module ers_storage #(
  parameter ADDR_W = `ERS_ADDR_W
) (
  input wire ref_clk,
  input wire wrEn,
  input wire [ADDR_W-1:0] wrAddr,
  input wire [7:0] wrData,
  input wire sectorWrEn,
  input wire [4:0] sectorAddr,
  input wire [ADDR_W-1:0] rdAddr,
  input wire [3:0] snAddr,
  input wire [127:0] factory_serial_number,
  output reg [7:0] arrayByte,
  output reg [7:0] sectorByte,
  output reg [7:0] snByte
);
  reg [7:0] mem [0:(1<<ADDR_W)-1];
  reg [7:0] sector [0:31];
  always @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (sectorWrEn) begin
      sector[sectorAddr] <= wrData;
    end
    arrayByte <= mem[rdAddr];
    sectorByte <= sector[sectorAddr];
  end
  // First serial byte is the most significant one
  always @* begin
    snByte = factory_serial_number[{~snAddr, 3'h0} +: 8];
  end
endmodule

// ---- test/ers_read_sequencer_asserts.sv ----
`timescale 1ns/10ps
// ----
// Bus-side checks
// ----
module ers_read_sequencer_asserts #(
  parameter ADDR_W = 12,
  parameter PAGE_W = 5
) (
  input wire ref_clk,
  input wire rstn,
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOutEnN,
  input wire chip_select_bit_high,
  input wire chip_select_bit_mid,
  input wire chip_select_bit_low,
  input wire sectorLocked,
  input wire [127:0] factory_serial_number,
  input wire busy,
  input wire [ADDR_W-1:0] addrCounter
);
  reg sclPrev_reg, sdaPrev_reg;
  reg [3:0] bitCnt_reg;
  reg [1:0] byteIdx_reg;
  reg [7:0] addrSh_reg;
  wire sclRise = sclIn & ~sclPrev_reg;
  wire startSeen = sclIn & sclPrev_reg & sdaPrev_reg & ~sdaIn;
  wire stopSeen = sclIn & sclPrev_reg & ~sdaPrev_reg & sdaIn;
  wire ackSlot = sclRise & (bitCnt_reg == 4'h8);
  wire csBits = addrSh_reg[3:1] == {chip_select_bit_high, chip_select_bit_mid, chip_select_bit_low};
  wire addrMatch = (addrSh_reg[7:5] == 3'h5) & csBits;
  // Bit and byte position on the wire, so slots can be judged without the design's state
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      bitCnt_reg <= 4'h0;
      byteIdx_reg <= 2'h0;
      addrSh_reg <= 8'h00;
    end else begin
      sclPrev_reg <= sclIn;
      sdaPrev_reg <= sdaIn;
      if (startSeen) begin
        bitCnt_reg <= 4'h0;
        byteIdx_reg <= 2'h0;
      end else if (sclRise) begin
        bitCnt_reg <= ackSlot ? 4'h0 : bitCnt_reg + 4'h1;
        if (ackSlot && byteIdx_reg != 2'h3)
          byteIdx_reg <= byteIdx_reg + 2'h1;
        if (byteIdx_reg == 2'h0 && !ackSlot)
          addrSh_reg <= {addrSh_reg[6:0], sdaIn};
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  line_moves_low_a: assert property (
    ($changed(sdaOutEnN) || (!sdaOutEnN && $changed(sdaOut))) |-> !sclIn)
    else $error("data line moved while clock high");
  idle_release_a: assert property ((!busy && !$past(busy)) |-> sdaOutEnN)
    else $error("line driven while idle");
  stop_idle_a: assert property (stopSeen |-> ##[1:6] !busy)
    else $error("busy after stop");
  start_busy_a: assert property (startSeen |-> ##[1:6] busy)
    else $error("start not taken");
  counter_hold_a: assert property ((!busy && !$past(busy)) |-> $stable(addrCounter))
    else $error("counter moved while idle");
  addr_ack_a: assert property ((ackSlot && byteIdx_reg == 2'h0 && addrMatch) |-> (!sdaOutEnN && !sdaOut))
    else $error("matching address not acknowledged");
  addr_nack_a: assert property ((ackSlot && byteIdx_reg == 2'h0 && !addrMatch) |-> sdaOutEnN)
    else $error("foreign address acknowledged");
  master_slot_a: assert property (
    (ackSlot && byteIdx_reg != 2'h0 && addrSh_reg[0] && addrMatch) |-> sdaOutEnN)
    else $error("line held in master slot");
endmodule
bind ers_read_sequencer ers_read_sequencer_asserts #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W)) chk (.ref_clk(ref_clk),
  .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOutEnN(sdaOutEnN),
  .chip_select_bit_high(chip_select_bit_high), .chip_select_bit_mid(chip_select_bit_mid),
  .chip_select_bit_low(chip_select_bit_low), .sectorLocked(sectorLocked),
  .factory_serial_number(factory_serial_number), .busy(busy), .addrCounter(addrCounter));

// ---- test/ers_bus_master.sv ----
`timescale 1ns/10ps
// ----
// Bus master model, open-drain data
// ----
module ers_bus_master #(
  parameter HALF = 10
) (
  input wire ref_clk,
  input wire sdaBus,
  output reg sclOut,
  output reg sdaDrv
);
  reg junk;
  initial begin
    sclOut = 1'b1;
    sdaDrv = 1'b1;
  end
  task hp(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Works from idle and as a repeated start
  task startC;
    begin
      sdaDrv <= 1'b1;
      hp(HALF);
      sclOut <= 1'b1;
      hp(HALF);
      sdaDrv <= 1'b0;
      hp(HALF);
      sclOut <= 1'b0;
      hp(2);
    end
  endtask
  task stopC;
    begin
      sdaDrv <= 1'b0;
      hp(HALF);
      sclOut <= 1'b1;
      hp(HALF);
      sdaDrv <= 1'b1;
      hp(HALF);
    end
  endtask
  // Data moves two cycles after the fall, never while the clock is high
  task bitX(input b, output r);
    begin
      sdaDrv <= b;
      hp(HALF);
      sclOut <= 1'b1;
      hp(HALF / 2);
      r = sdaBus;
      hp(HALF / 2);
      sclOut <= 1'b0;
      hp(2);
    end
  endtask
  task wrByte(input [7:0] v, output nak);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bitX(v[k], junk);
      bitX(1'b1, nak);
    end
  endtask
  task rdByte(input ack, output [7:0] v);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bitX(1'b1, v[k]);
      bitX(!ack, junk);
    end
  endtask
endmodule

// ---- test/eeprom_read_sequencer_tb.sv ----
`timescale 1ns/10ps
// ----
// Read sequencer bench
// ----
module eeprom_read_sequencer_tb;
  localparam integer LIMIT = 90000;
  reg ref_clk, rstn, csHigh, csMid, csLow, sectorLocked, nak;
  reg [127:0] sn;
  reg [7:0] mem [0:4095];
  reg [7:0] sec [0:31];
  reg [7:0] hi, lo, d, e, w;
  integer n_fail, samples_checked, cyc, i, k;
  wire sclIn, sdaDrv, sdaOut, sdaOutEnN, busy;
  wire [11:0] addrCounter;
  wire sdaBus = (sdaOutEnN ? 1'b1 : sdaOut) & sdaDrv;
  ers_bus_master mst (.ref_clk(ref_clk), .sdaBus(sdaBus), .sclOut(sclIn), .sdaDrv(sdaDrv));
  ers_read_sequencer dut (.ref_clk(ref_clk), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaBus), .sdaOut(sdaOut),
    .sdaOutEnN(sdaOutEnN), .chip_select_bit_high(csHigh), .chip_select_bit_mid(csMid),
    .chip_select_bit_low(csLow), .sectorLocked(sectorLocked), .factory_serial_number(sn),
    .busy(busy), .addrCounter(addrCounter));
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  task fail(input [8*12-1:0] m);
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t %0s", $time, m);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  function [7:0] devAddr(input sp, input rw);
    devAddr = {3'h5, sp, csHigh, csMid, csLow, rw};
  endfunction
  function [7:0] expByte(input [1:0] kind, input [11:0] a);
    case (kind)
      2'h0: expByte = mem[a];
      2'h1: expByte = sn[8'h7f - {a[3:0], 3'h0} -: 8];
      2'h2: expByte = sec[a[4:0]];
      default: expByte = {6'h00, sectorLocked, 1'b0};
    endcase
  endfunction
  task setPtr(input sp, input [7:0] h, input [7:0] l);
    begin
      mst.startC;
      mst.wrByte(devAddr(sp, 1'b0), nak);
      mst.wrByte(h, nak);
      mst.wrByte(l, nak);
    end
  endtask
  task rdSeq(input sp, input [1:0] kind, input [11:0] base, input integer n);
    begin
      mst.startC;
      mst.wrByte(devAddr(sp, 1'b1), nak);
      for (k = 0; k < n; k = k + 1) begin
        mst.rdByte(k < n - 1, d);
        e = expByte(kind, base + k[11:0]);
        samples_checked = samples_checked + 1;
        if (nak !== 1'b0 || ^d === 1'bx || (kind == 2'h3 ? d & 8'h02 : d) !== e)
          fail("read byte");
      end
      mst.stopC;
      samples_checked = samples_checked + 1;
      if (busy !== 1'b0 || (kind == 2'h0 && addrCounter !== base + n[11:0]))
        fail("after stop");
    end
  endtask
  task wrSeq(input sp, input [7:0] h, input [7:0] l, input integer n);
    begin
      setPtr(sp, h, l);
      for (k = 0; k < n; k = k + 1) begin
        w = $urandom;
        mst.wrByte(w, nak);
        samples_checked = samples_checked + 1;
        if (nak !== (sp & sectorLocked))
          fail("write ack");
        if (!sp)
          mem[{h[3:0], l[7:5], l[4:0] + k[4:0]}] = w;
        else if (!sectorLocked)
          sec[{l[4:0] + k[4:0]}] = w;
      end
      if (sp & sectorLocked)
        mst.startC;
      mst.stopC;
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    sectorLocked = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    i = $urandom(6580);
    {csHigh, csMid, csLow} = $urandom;
    sn = {$urandom, $urandom, $urandom, $urandom};
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wrSeq(1'b0, 8'h00, 8'hfe, 4);
    setPtr(1'b0, 8'h00, 8'hfe);
    rdSeq(1'b0, 2'h0, 12'h0fe, 2);
    setPtr(1'b0, 8'h00, 8'he0);
    rdSeq(1'b0, 2'h0, 12'h0e0, 2);
    wrSeq(1'b0, 8'h0f, 8'hff, 1);
    wrSeq(1'b0, 8'h00, 8'h00, 2);
    setPtr(1'b0, 8'h0f, 8'hff);
    rdSeq(1'b0, 2'h0, 12'hfff, 2);
    rdSeq(1'b0, 2'h0, 12'h001, 1);
    for (i = 0; i < 4; i = i + 1) begin
      hi = $urandom;
      lo = $urandom;
      wrSeq(1'b0, hi, lo, 3);
      setPtr(1'b0, hi, lo);
      rdSeq(1'b0, 2'h0, {hi[3:0], lo}, 1);
      setPtr(1'b1, hi | 8'h02, lo);
      rdSeq(1'b1, 2'h1, {8'h00, lo[3:0]}, 18);
    end
    wrSeq(1'b1, 8'h00, 8'h00, 32);
    setPtr(1'b1, hi & 8'hf9, 8'h1e);
    rdSeq(1'b1, 2'h2, 12'h01e, 4);
    for (i = 0; i < 2; i = i + 1) begin
      sectorLocked <= i[0];
      setPtr(1'b1, {hi[7:3], 2'h2, hi[0]}, lo);
      rdSeq(1'b1, 2'h3, 12'h000, 3);
    end
    wrSeq(1'b1, 8'h00, 8'h05, 1);
    setPtr(1'b1, 8'h00, 8'h05);
    rdSeq(1'b1, 2'h2, 12'h005, 1);
    setPtr(1'b0, 8'h00, 8'h00);
    for (i = 0; i < 4; i = i + 1)
      mst.bitX(~mem[0][i], nak);
    mst.startC;
    mst.stopC;
    setPtr(1'b0, 8'h00, 8'h00);
    rdSeq(1'b0, 2'h0, 12'h000, 1);
    mst.startC;
    mst.wrByte(devAddr(1'b0, 1'b1) ^ 8'h08, nak);
    samples_checked = samples_checked + 1;
    if (nak !== 1'b1 || busy !== 1'b0)
      fail("mismatch");
    mst.stopC;
    print_verdict;
  end
endmodule
